// *** rtl/tx_pcs_pkg.sv ***
// Functional notes
// - byte serializer sends each fabric word as two half-width words in turn
// - bypassed serializer passes 8/10/16/20-bit words through unchanged
// - phase-compensation fifo always sits in the path, never bypassed
// - fabric width 8/10 or 16/20 single, 16/20 or 32/40 double
// - width toward serializer 8/10 single, 16/20 double, either way
// - byte ordering swap only acts with serialization enabled
// - state machine runs in xaui or gige, passes words through in basic and pcie
// - pcie receiver detection: pulse lane in electrical idle, sample reflection
// - force-electrical-idle input idles the buffer, in pcie mode only
// - gige, single width only: every idle ordered set becomes first or second idle set
// - first set K28.5 then D5.6; second set K28.5 then D16.2
// - configuration sets K28.5+D21.5 and K28.5+D2.2 never created or altered
// - each emitted idle set ends with negative running disparity
// - xaui: data passes as data; control 9C becomes K28.4
// - xaui idle 07 gives K28.0/K28.3/K28.5, K28.5 right after terminate
// - K28.0/K28.5 chosen by x^7+x^6+1 sequence, K28.3 with 16..31 idle words between
// - running disparity starts negative; force inputs may override it
// - lock status output reports transmitter pll lock
package tx_pcs_pkg;
   localparam int        SYM_W      = 10;
   localparam int        FIFO_DEPTH = 4;
   localparam int        PTR_W      = 2;
   localparam int        ADDR_W     = 8;
   localparam int        CTRL_W     = 8;

   typedef struct packed {
      logic             k;
      logic [SYM_W-1:0] v;
   } sym_t;
   typedef struct packed { sym_t [3:0] s; } fab_word_t;
   typedef struct packed { sym_t [1:0] s; } pcs_word_t;
   typedef enum logic [1:0] {PROTO_BASIC, PROTO_PCIE, PROTO_XAUI, PROTO_GIGE} proto_t;

   localparam logic [ADDR_W-1:0] CTRL_OFF = 8'h00;
   localparam logic [ADDR_W-1:0] STAT_OFF = 8'h04;
   localparam logic [CTRL_W-1:0] CTRL_RST = 8'h00;
   localparam int        CTRL_PROTO_LSB = 0;
   localparam int        CTRL_DBL_BIT   = 2;
   localparam int        CTRL_SER_BIT   = 3;
   localparam int        CTRL_SYM10_BIT = 4;
   localparam int        CTRL_SWAP_BIT  = 5;
   localparam int        CTRL_FDISP_BIT = 6;
   localparam int        CTRL_DVAL_BIT  = 7;
   localparam int        CTRL_FRST_BIT  = 8;
   localparam int        CTRL_RXDET_BIT = 9;

   localparam logic [7:0] K28_0 = 8'h1C;
   localparam logic [7:0] K28_3 = 8'h7C;
   localparam logic [7:0] K28_4 = 8'h9C;
   localparam logic [7:0] K28_5 = 8'hBC;
   localparam logic [7:0] K27_7 = 8'hFB;
   localparam logic [7:0] K29_7 = 8'hFD;
   localparam logic [7:0] K30_7 = 8'hFE;
   localparam logic [7:0] D5_6  = 8'hC5;
   localparam logic [7:0] D16_2 = 8'h50;
   localparam logic [7:0] D21_5 = 8'hB5;
   localparam logic [7:0] D2_2  = 8'h42;
   localparam logic [7:0] XGMII_IDLE = 8'h07;
   localparam logic [7:0] XGMII_SEQ  = 8'h9C;
   localparam logic [6:0] PRBS_SEED  = 7'h7F;
   localparam logic [4:0] A_CNT_RST  = 5'h10;

   localparam int        CLK_NS          = 25;
   localparam int        RXDET_PULSE_NS  = 100;
   localparam int        RXDET_WAIT_NS   = 1000;
   localparam logic [5:0] RXDET_PULSE_CYC = 6'((RXDET_PULSE_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [5:0] RXDET_WAIT_CYC  = 6'((RXDET_WAIT_NS + CLK_NS - 1) / CLK_NS);
endpackage

// *** rtl/tx_phase_fifo.sv ***
`timescale 1ns/1ps
module tx_phase_fifo
   import tx_pcs_pkg::*;
(
   input  wire logic      clk,       // clock
   input  wire logic      rst_n,     // async reset, active low
   input  wire logic      flush,     // pll unlocked: pointers held cleared
   input  wire logic      init_req,  // pointer initialization pulse
   input  wire logic      in_valid,  // fabric word offered
   input  wire fab_word_t in_data,   // fabric word
   output logic           in_ready,  // registered accept
   output logic           init,      // pointers initialized
   output logic           out_valid, // word available
   output fab_word_t      out_data,  // head word
   input  wire logic      out_ready  // head consumed
);
   fab_word_t        mem      [FIFO_DEPTH];
   fab_word_t        next_mem [FIFO_DEPTH];
   logic [PTR_W-1:0] wptr, rptr, next_wptr, next_rptr;
   logic [PTR_W:0]   count, next_count;
   logic             next_init, next_in_ready, push, pop;

   assign out_valid = init & (count != '0);
   assign out_data  = mem[rptr];
   assign push      = in_valid & in_ready;
   assign pop       = out_valid & out_ready;

   always_comb begin
      next_mem   = mem;
      next_wptr  = wptr;
      next_rptr  = rptr;
      next_count = count;
      next_init  = init;
      if (flush) begin
         next_wptr  = '0;
         next_rptr  = '0;
         next_count = '0;
         next_init  = 1'b0;
      end else if (init_req) begin
         next_wptr  = '0;
         next_rptr  = '0;
         next_count = '0;
         next_init  = 1'b1;
      end else begin
         if (push) begin
            next_mem[wptr] = in_data;
            next_wptr      = wptr + 1'b1;
         end
         if (pop)
            next_rptr = rptr + 1'b1;
         next_count = count + (PTR_W+1)'(push) - (PTR_W+1)'(pop);
      end
      next_in_ready = next_init & (next_count != (PTR_W+1)'(FIFO_DEPTH));
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         for (int i = 0; i < FIFO_DEPTH; i++)
            mem[i] <= '0;
         wptr     <= '0;
         rptr     <= '0;
         count    <= '0;
         init     <= 1'b0;
         in_ready <= 1'b0;
      end else begin
         mem      <= next_mem;
         wptr     <= next_wptr;
         rptr     <= next_rptr;
         count    <= next_count;
         init     <= next_init;
         in_ready <= next_in_ready;
      end
   end
endmodule

// *** rtl/tx_state_machine.sv ***
`timescale 1ns/1ps
module tx_state_machine
   import tx_pcs_pkg::*;
(
   input  wire logic      clk,       // clock
   input  wire logic      rst_n,     // async reset, active low
   input  wire proto_t    proto,     // configured protocol
   input  wire pcs_word_t in_word,   // symbols from the byte serializer
   input  wire logic      in_valid,  // symbols present
   input  wire logic      rd_pos,    // running disparity positive
   output pcs_word_t      out_word,  // symbols toward the encoder
   output logic           out_valid  // out_word valid
);
   logic [6:0] prbs, next_prbs;
   logic [4:0] a_cnt, next_a_cnt;
   logic [1:0] last_term, next_last_term;
   logic       k_seen, k_rd, next_k_seen, next_k_rd;
   pcs_word_t  next_out_word;

   always_comb begin
      logic [7:0] idle_code;
      logic       used;
      idle_code      = K28_0;
      used           = 1'b0;
      next_out_word  = in_word;
      next_prbs      = prbs;
      next_a_cnt     = a_cnt;
      next_last_term = last_term;
      next_k_seen    = k_seen;
      next_k_rd      = k_rd;
      if (in_valid) begin
         unique case (proto)
            PROTO_GIGE: begin
               // configuration sets (K28.5 then D21.5 or D2.2) stay as sent
               if (k_seen && !in_word.s[0].k && in_word.s[0].v[7:0] != D21_5 &&
                   in_word.s[0].v[7:0] != D2_2) begin
                  next_out_word.s[0].v = {2'b00, (k_rd ? D16_2 : D5_6)};
               end
               next_k_seen = in_word.s[0].k && (in_word.s[0].v[7:0] == K28_5);
               if (next_k_seen)
                  next_k_rd = rd_pos;
            end
            PROTO_XAUI: begin
               if (a_cnt == '0)
                  idle_code = K28_3;
               else
                  idle_code = prbs[0] ? K28_5 : K28_0;
               for (int i = 0; i < 2; i++) begin
                  if (in_word.s[i].k) begin
                     unique case (in_word.s[i].v[7:0])
                        XGMII_IDLE: begin
                           next_out_word.s[i].v = {2'b00, (last_term[i] ? K28_5 : idle_code)};
                           used                 = 1'b1;
                        end
                        XGMII_SEQ: next_out_word.s[i].v = {2'b00, K28_4};
                        K27_7, K29_7, K30_7: ;
                        default: next_out_word.s[i].v = {2'b00, K30_7};
                     endcase
                  end
                  next_last_term[i] = in_word.s[i].k && (in_word.s[i].v[7:0] == K29_7);
               end
               if (used) begin
                  next_prbs  = {prbs[5:0], prbs[6] ^ prbs[5]};
                  next_a_cnt = (a_cnt == '0) ? {1'b1, prbs[4:1]} : a_cnt - 1'b1;
               end
            end
            PROTO_BASIC, PROTO_PCIE: ;
         endcase
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         prbs      <= PRBS_SEED;
         a_cnt     <= A_CNT_RST;
         last_term <= '0;
         k_seen    <= 1'b0;
         k_rd      <= 1'b0;
         out_word  <= '0;
         out_valid <= 1'b0;
      end else begin
         prbs      <= next_prbs;
         a_cnt     <= next_a_cnt;
         last_term <= next_last_term;
         k_seen    <= next_k_seen;
         k_rd      <= next_k_rd;
         out_word  <= next_out_word;
         out_valid <= in_valid;
      end
   end
endmodule

// *** rtl/serial_tx_pcs_path.sv ***
`timescale 1ns/1ps
module serial_tx_pcs_path
   import tx_pcs_pkg::*;
(
   input  wire logic              pclk,             // 40 MHz clock
   input  wire logic              presetn,          // async reset, active low
   input  wire logic [ADDR_W-1:0] paddr,            // apb address
   input  wire logic              psel,             // apb select
   input  wire logic              penable,          // apb enable
   input  wire logic              pwrite,           // apb direction
   input  wire logic [31:0]       pwdata,           // apb write data
   output logic [31:0]            prdata,           // apb read data
   output logic                   pready,           // apb ready
   output logic                   pslverr,          // apb error, unmapped address
   input  wire fab_word_t         tx_word,          // fabric word, slot 0 = symbol A
   input  wire logic              tx_valid,         // fabric word offered
   output logic                   tx_ready,         // fifo accepts word
   input  wire logic              tx_forceelecidle, // fabric electrical idle request
   input  wire logic              pll_locked_pin,   // asynchronous pll lock level
   input  wire logic              rx_reflect_pin,   // asynchronous reflection sense
   input  wire logic              enc_rd_pos,       // encoder disparity positive
   output pcs_word_t              pcs_word,         // symbols toward the encoder
   output logic                   pcs_valid,        // pcs_word valid
   output logic                   tx_elec_idle,     // buffer electrical idle
   output logic                   tx_force_disp,    // disparity force to encoder
   output logic                   tx_disp_val,      // forced disparity value
   output logic                   rxdet_pulse,      // detection pulse onto lane
   output logic                   pll_locked        // filtered lock status
);
   typedef enum {RD_IDLE, RD_PULSE, RD_WAIT} rxdet_state_t;

   // register file
   logic [CTRL_W-1:0] ctrl, next_ctrl;
   logic [31:0]       next_prdata, status;
   logic              next_pready, next_pslverr;
   logic              fifo_rst, next_fifo_rst;
   logic              rxdet_start, next_rxdet_start;
   logic              hit, wr_ctrl;
   logic              apb_access, rd_busy;

   // mode decode
   proto_t            proto;
   logic              dbl, ser_en, sym10, swap;

   // pin synchronisers
   logic [1:0]        sync1, sync2, sync3, level, next_level;

   // serializer
   fab_word_t         cur_word, next_cur_word, fifo_data;
   logic              have_hi, next_have_hi;
   logic              fifo_valid, fifo_ready, fifo_init;
   pcs_word_t         ser_word;
   logic              ser_valid;

   // receiver detection and disparity
   rxdet_state_t      rd_state, next_rd_state;
   logic [5:0]        rd_cnt, next_rd_cnt;
   logic              rx_present, next_rx_present;
   logic              next_elec_idle, next_rxdet_pulse;
   logic              rd_pos, next_rd_pos;

   assign proto  = proto_t'(ctrl[CTRL_PROTO_LSB +: 2]);
   assign dbl    = ctrl[CTRL_DBL_BIT];
   assign ser_en = ctrl[CTRL_SER_BIT];
   assign sym10  = ctrl[CTRL_SYM10_BIT];
   assign swap   = ctrl[CTRL_SWAP_BIT] & ser_en;

   assign rd_busy    = (rd_state != RD_IDLE);
   assign status     = {26'h0,
                        rd_pos,
                        rx_present,
                        rd_busy,
                        fifo_init,
                        level[0],
                        1'b0};
   assign hit        = (paddr == CTRL_OFF) || (paddr == STAT_OFF);
   assign apb_access = psel & penable & pready;
   assign wr_ctrl    = apb_access & pwrite & (paddr == CTRL_OFF);

   // apb slave
   // every setup is answered one cycle later, so no wait states exist
   always_comb begin
      next_pready      = psel & ~penable & ~pready;
      next_prdata      = prdata;
      next_pslverr     = pslverr;
      next_ctrl        = ctrl;
      next_fifo_rst    = 1'b0;
      next_rxdet_start = 1'b0;

      if (psel & ~penable) begin
         next_pslverr = ~hit;
         if (paddr == CTRL_OFF)
            next_prdata = {24'h000000, ctrl};
         else if (paddr == STAT_OFF)
            next_prdata = status;
         else
            next_prdata = 32'h00000000;
      end

      if (wr_ctrl) begin
         next_ctrl        = pwdata[CTRL_W-1:0];
         next_fifo_rst    = pwdata[CTRL_FRST_BIT];
         next_rxdet_start = pwdata[CTRL_RXDET_BIT];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl        <= CTRL_RST;
         prdata      <= 32'h00000000;
         pready      <= 1'b0;
         pslverr     <= 1'b0;
         fifo_rst    <= 1'b0;
         rxdet_start <= 1'b0;
      end else begin
         ctrl        <= next_ctrl;
         prdata      <= next_prdata;
         pready      <= next_pready;
         pslverr     <= next_pslverr;
         fifo_rst    <= next_fifo_rst;
         rxdet_start <= next_rxdet_start;
      end
   end

   // forced disparity goes straight from the control flops
   assign tx_force_disp = ctrl[CTRL_FDISP_BIT];
   assign tx_disp_val   = ctrl[CTRL_DVAL_BIT];

   // pin synchronisers
   // a level only changes when stages two and three agree, so one metastable
   // sample never reaches the fifo flush or the detection result
   always_comb begin
      for (int i = 0; i < 2; i++)
         next_level[i] = (sync2[i] == sync3[i]) ? sync3[i] : level[i];
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sync1 <= 2'b00;
         sync2 <= 2'b00;
         sync3 <= 2'b00;
         level <= 2'b00;
      end else begin
         sync1 <= {rx_reflect_pin, pll_locked_pin};
         sync2 <= sync1;
         sync3 <= sync2;
         level <= next_level;
      end
   end

   assign pll_locked = level[0];

   // phase compensation fifo
   // flushed while unlocked; software re-inits the pointers after relock
   tx_phase_fifo u_fifo (
      .clk       (pclk),
      .rst_n     (presetn),
      .flush     (~level[0]),
      .init_req  (fifo_rst),
      .in_valid  (tx_valid),
      .in_data   (tx_word),
      .in_ready  (tx_ready),
      .init      (fifo_init),
      .out_valid (fifo_valid),
      .out_data  (fifo_data),
      .out_ready (fifo_ready)
   );

   // byte serializer
   // half 0 is the lower symbols, half 1 the upper; swap reverses the order
   function automatic pcs_word_t pick_half(input fab_word_t w, input logic h,
                                           input logic d, input logic s10);
      pcs_word_t r;
      r      = '0;
      r.s[0] = d ? w.s[{h, 1'b0}] : w.s[{1'b0, h}];
      if (d)
         r.s[1] = w.s[{h, 1'b1}];
      if (!s10) begin
         r.s[0].v[9:8] = 2'b00;
         r.s[1].v[9:8] = 2'b00;
      end
      return r;
   endfunction

   // the fifo is held off while the second half is still pending
   assign fifo_ready = ~have_hi;

   always_comb begin
      next_cur_word = cur_word;
      next_have_hi  = have_hi;
      ser_word      = '0;
      ser_valid     = 1'b0;

      if (have_hi) begin
         ser_word     = pick_half(cur_word, ~swap, dbl, sym10);
         ser_valid    = 1'b1;
         next_have_hi = 1'b0;
      end else if (fifo_valid) begin
         ser_valid = 1'b1;
         if (ser_en) begin
            ser_word      = pick_half(fifo_data, swap, dbl, sym10);
            next_cur_word = fifo_data;
            next_have_hi  = 1'b1;
         end else begin
            ser_word = pick_half(fifo_data, 1'b0, dbl, sym10);
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cur_word <= '0;
         have_hi  <= 1'b0;
      end else begin
         cur_word <= next_cur_word;
         have_hi  <= next_have_hi;
      end
   end

   // protocol state machine
   tx_state_machine u_sm (
      .clk       (pclk),
      .rst_n     (presetn),
      .proto     (proto),
      .in_word   (ser_word),
      .in_valid  (ser_valid),
      .rd_pos    (rd_pos),
      .out_word  (pcs_word),
      .out_valid (pcs_valid)
   );

   // running disparity view
   // forcing wins over the encoder so software can steer the next idle set
   always_comb begin
      next_rd_pos = rd_pos;

      if (ctrl[CTRL_FDISP_BIT])
         next_rd_pos = ctrl[CTRL_DVAL_BIT];
      else if (pcs_valid)
         next_rd_pos = enc_rd_pos;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         rd_pos <= 1'b0;
      else
         rd_pos <= next_rd_pos;
   end

   // receiver detection and electrical idle
   // detection is refused outside pcie so the lane is never pulsed mid-traffic
   always_comb begin
      next_rd_state   = rd_state;
      next_rd_cnt     = rd_cnt;
      next_rx_present = rx_present;

      unique case (rd_state)
         RD_IDLE: begin
            if (rxdet_start && proto == PROTO_PCIE) begin
               next_rd_state = RD_PULSE;
               next_rd_cnt   = RXDET_PULSE_CYC - 1'b1;
            end
         end
         RD_PULSE: begin
            if (rd_cnt == '0) begin
               next_rd_state = RD_WAIT;
               next_rd_cnt   = RXDET_WAIT_CYC - 1'b1;
            end else begin
               next_rd_cnt = rd_cnt - 1'b1;
            end
         end
         RD_WAIT: begin
            if (rd_cnt == '0) begin
               next_rd_state   = RD_IDLE;
               next_rx_present = level[1];
            end else begin
               next_rd_cnt = rd_cnt - 1'b1;
            end
         end
      endcase
      next_rxdet_pulse = (next_rd_state == RD_PULSE);
      next_elec_idle   = (proto == PROTO_PCIE) &&
                         (tx_forceelecidle || next_rd_state != RD_IDLE);
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rd_state     <= RD_IDLE;
         rd_cnt       <= 6'h00;
         rx_present   <= 1'b0;
         rxdet_pulse  <= 1'b0;
         tx_elec_idle <= 1'b0;
      end else begin
         rd_state     <= next_rd_state;
         rd_cnt       <= next_rd_cnt;
         rx_present   <= next_rx_present;
         rxdet_pulse  <= next_rxdet_pulse;
         tx_elec_idle <= next_elec_idle;
      end
   end
endmodule

// *** tb/tx_pcs_checker_assertions.sv ***
`timescale 1ns/1ps
module tx_pcs_checker (
   input wire logic        pclk,           // clock
   input wire logic        presetn,        // reset
   input wire logic        psel,           // select
   input wire logic        penable,        // enable
   input wire logic        pwrite,         // direction
   input wire logic        pready,         // ready
   input wire logic        pslverr,        // error
   input wire logic [31:0] prdata,         // read data
   input wire logic        tx_valid,       // offer
   input wire logic        tx_ready,       // accept
   input wire logic        pcs_valid,      // symbols out
   input wire logic        pll_locked_pin, // raw lock
   input wire logic        pll_locked,     // lock
   input wire logic        rxdet_pulse,    // probe pulse
   input wire logic        tx_elec_idle    // buffer idle
);
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   a_apb_answer: assert property (psel && !penable |=> pready)
      else $error("no ready after setup");
   a_apb_single: assert property (pready |=> !pready)
      else $error("ready held");
   a_err_nodata: assert property (pready && pslverr |-> prdata == 32'h0)
      else $error("refused read gave data");
   a_fifo_path: assert property (tx_valid && tx_ready |-> ##[2:12] pcs_valid)
      else $error("pushed word never left");
   a_lock_refuse: assert property (!pll_locked [*2] |-> !tx_ready)
      else $error("accepting while unlocked");
   a_lock_filter: assert property ($rose(pll_locked) |-> $past(pll_locked_pin, 2))
      else $error("lock without pin");
   a_pulse_len: assert property ($rose(rxdet_pulse) |-> rxdet_pulse [*4] ##1 !rxdet_pulse)
      else $error("probe pulse length");
   a_pulse_idle: assert property (rxdet_pulse |-> tx_elec_idle)
      else $error("probe while driving");
   a_pulse_cause: assert property ($rose(rxdet_pulse) |->
      $past(pwrite && penable && pready, 2) || $past(pwrite && penable && pready, 3))
      else $error("probe without write");
endmodule

bind serial_tx_pcs_path tx_pcs_checker u_tx_pcs_checker (.pclk, .presetn, .psel, .penable,
   .pwrite, .pready, .pslverr, .prdata, .tx_valid, .tx_ready, .pcs_valid, .pll_locked_pin,
   .pll_locked, .rxdet_pulse, .tx_elec_idle);

// *** tb/fabric_src.sv ***
`timescale 1ns/1ps
module fabric_src
   import tx_pcs_pkg::*;
(
   input  wire logic pclk,            // clock
   input  wire logic tx_ready,        // accept
   output fab_word_t tx_word = '0,    // word
   output logic      tx_valid = 1'b0  // offer
);
   // offer held until the taking edge; bus then scrambled so stale data is never reused
   task automatic send(input fab_word_t w, output logic ok);
      int n = 0;
      tx_word  <= w;
      tx_valid <= 1'b1;
      ok = 1'b0;
      while (!ok && n < 200) begin
         @(posedge pclk);
         ok = (tx_ready === 1'b1);
         n++;
      end
      tx_valid <= 1'b0;
      tx_word  <= ~w;
   endtask
endmodule

// *** tb/testbench.sv ***
`timescale 1ns/1ps
module testbench import tx_pcs_pkg::*; ;
   typedef struct packed {
      logic [7:0]  c;
      logic        r;
      logic [43:0] w;
      logic [43:0] e;
   } row_t;
   localparam logic [10:0] Z = 11'h000, A = 11'h011, B = 11'h022, C = 11'h033;
   localparam logic [10:0] D = 11'h044, K = 11'h4BC;
   localparam logic [43:0] W = {D, C, B, A};
   logic              pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
   logic              pwrite = 1'b0, tx_forceelecidle = 1'b0, pll_locked_pin = 1'b1;
   logic              rx_reflect_pin = 1'b0, enc_rd_pos = 1'b0, ok;
   logic              pready, pslverr, tx_valid, tx_ready, pcs_valid, tx_elec_idle;
   logic              tx_force_disp, tx_disp_val, rxdet_pulse, pll_locked;
   logic [ADDR_W-1:0] paddr = '0;
   logic [31:0]       pwdata = '0, prdata, rd;
   logic [21:0]       m;
   fab_word_t         tx_word;
   pcs_word_t         pcs_word, g;
   int                errors, tests_run, k3, last, seen, n;
   row_t rows [16] = '{
      '{8'h00, 1'b0, W, {Z, Z, Z, A}}, '{8'h20, 1'b0, W, {Z, Z, Z, A}},
      '{8'h04, 1'b0, W, {Z, Z, B, A}}, '{8'h08, 1'b0, W, {Z, B, Z, A}},
      '{8'h28, 1'b0, W, {Z, A, Z, B}}, '{8'h0C, 1'b0, W, {D, C, B, A}},
      '{8'h2C, 1'b0, W, {B, A, D, C}}, '{8'h00, 1'b0, {D, C, B, 11'h3A5}, {Z, Z, Z, 11'h0A5}},
      '{8'h10, 1'b0, {D, C, B, 11'h3A5}, {Z, Z, Z, 11'h3A5}},
      '{8'h0B, 1'b0, {D, C, 11'h04A, K}, {Z, 11'h0C5, Z, K}},
      '{8'h0B, 1'b1, {D, C, 11'h0B5, K}, {Z, 11'h0B5, Z, K}},
      '{8'h0B, 1'b1, {D, C, 11'h04A, K}, {Z, 11'h050, Z, K}},
      '{8'h02, 1'b1, {D, C, B, 11'h4FD}, {Z, Z, Z, 11'h4FD}},
      '{8'h02, 1'b1, {D, C, B, 11'h407}, {Z, Z, Z, 11'h4BC}},
      '{8'h02, 1'b1, {D, C, B, 11'h49C}, {Z, Z, Z, 11'h49C}},
      '{8'h02, 1'b1, {D, C, B, 11'h455}, {Z, Z, Z, 11'h4FE}}};

`define CHK(got, want) begin tests_run++; if ((got) !== (want)) begin errors++; \
   $display("Error %0t: got %h want %h", $time, got, want); end end

   always #12.5 pclk = ~pclk;

   serial_tx_pcs_path u_serial_tx_pcs_path (.pclk, .presetn, .paddr, .psel, .penable, .pwrite,
      .pwdata, .prdata, .pready, .pslverr, .tx_word, .tx_valid, .tx_ready, .tx_forceelecidle,
      .pll_locked_pin, .rx_reflect_pin, .enc_rd_pos, .pcs_word, .pcs_valid, .tx_elec_idle,
      .tx_force_disp, .tx_disp_val, .rxdet_pulse, .pll_locked);
   fabric_src u_fabric_src (.pclk, .tx_ready, .tx_word, .tx_valid);

   task automatic stop_test();
      $display("errors=%0d tests_run=%0d", errors, tests_run);
      if (errors == 0 && tests_run > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   task automatic hang();
      errors++;
      stop_test();
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int i = 0;
      psel   <= 1'b1;
      pwrite <= w;
      paddr  <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         i++;
      end while (pready !== 1'b1 && i < 50);
      rd = prdata;
      ok = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      if (i >= 50) hang();
      @(posedge pclk);
   endtask
   task automatic grab();
      int i = 0;
      do begin
         @(posedge pclk);
         i++;
      end while (pcs_valid !== 1'b1 && i < 50);
      if (i >= 50) hang();
      g = pcs_word;
   endtask
   task automatic relock();
      int i = 0;
      pll_locked_pin <= 1'b1;
      while (pll_locked !== 1'b1 && i < 50) begin
         @(posedge pclk);
         i++;
      end
      if (i >= 50) hang();
   endtask

   initial begin
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      `CHK(tx_force_disp, 1'b0)
      relock();
      apb(1'b1, CTRL_OFF, 32'h100);
      apb(1'b0, CTRL_OFF, 32'h0);
      `CHK(rd, 32'h0)
      apb(1'b0, 8'h08, 32'h0);
      `CHK({ok, rd}, 33'h100000000)
      apb(1'b0, STAT_OFF, 32'h0);
      `CHK(rd[2:1], 2'b11)
      apb(1'b1, CTRL_OFF, 32'hC0);
      `CHK({tx_force_disp, tx_disp_val}, 2'b11)
      $display("test registers done");
      foreach (rows[i]) begin
         apb(1'b1, CTRL_OFF, {24'h0, rows[i].c});
         enc_rd_pos <= rows[i].r;
         u_fabric_src.send(rows[i].w, ok);
         m = rows[i].c[2] ? 22'h3FFFFF : 22'h0007FF;
         grab();
         `CHK(g & m, rows[i].e[21:0] & m)
         if (rows[i].c[3]) begin
            grab();
            `CHK(g & m, rows[i].e[43:22] & m)
         end
      end
      $display("test rows done");
      last = -99;
      for (int j = 0; j < 40; j++) begin
         u_fabric_src.send({D, C, B, 11'h407}, ok);
         grab();
         `CHK(g.s[0] inside {11'h41C, 11'h47C, 11'h4BC}, 1'b1)
         if (g.s[0] === 11'h47C) begin
            `CHK(j - last >= 16, 1'b1)
            last = j;
            k3++;
         end
         seen |= (g.s[0] === 11'h41C) + 2 * (g.s[0] === 11'h4BC);
      end
      `CHK({k3 > 0, seen}, 33'h100000003)
      $display("test idle run done");
      apb(1'b1, CTRL_OFF, 32'h01);
      tx_forceelecidle <= 1'b1;
      repeat (2) @(posedge pclk);
      `CHK(tx_elec_idle, 1'b1)
      apb(1'b1, CTRL_OFF, 32'h200);
      @(posedge pclk);
      `CHK(tx_elec_idle, 1'b0)
      apb(1'b0, STAT_OFF, 32'h0);
      `CHK(rd[3], 1'b0)
      tx_forceelecidle <= 1'b0;
      rx_reflect_pin <= 1'b1;
      apb(1'b1, CTRL_OFF, 32'h201);
      apb(1'b0, STAT_OFF, 32'h0);
      `CHK(rd[3], 1'b1)
      n = 0;
      do begin
         apb(1'b0, STAT_OFF, 32'h0);
         n++;
      end while (rd[3] !== 1'b0 && n < 40);
      `CHK(rd[4:3], 2'b10)
      $display("test idle and detect done");
      pll_locked_pin <= 1'b0;
      repeat (8) @(posedge pclk);
      `CHK({pll_locked, tx_ready}, 2'b00)
      relock();
      apb(1'b0, STAT_OFF, 32'h0);
      `CHK(rd[2:1], 2'b01)
      apb(1'b1, CTRL_OFF, 32'h100);
      apb(1'b0, STAT_OFF, 32'h0);
      `CHK(rd[2], 1'b1)
      $display("test lock loss done");
      stop_test();
   end
endmodule
